// File: src/uit_dev_end.sv
// Device end: gap, response-window and response-timeout timing.
// Assumes bit_tick_i is a one-cycle strobe at half the current bit period.
//
// Behaviour
// - LS/FS gap from EOP end to SOP
// - Device waits at least two bits before sending
// - Host keeps J two bits before packet
// - Detachable device responds within 6.5 bits
// - Captive device responds under 7.5 bits
// - Limits counted at the packet's own rate
// - Host responds within 7.5 bits
// - No upper gap limit across transactions
// - HS gap from idle return to idle exit
// - HS turn-around at least eight bits
// - Host back-to-back HS gap at least 88
// - Host in-transaction HS gap at most 192
// - Host HS response within 192 bits
// - Detachable HS device responds within 192
// - Captive HS device within 192 plus 52 ns
// - Missing response invalidates the transaction
// - LS/FS timeout between 16 and 18 bits
// - Host waits at least 18 bits
// - HS timeout between 736 and 816 bits
`timescale 1ns/10ps
module uit_dev_end
   import uit_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic clk_en_i,
   // Timing
   input  wire logic bit_tick_i,
   input  wire logic captive_i,
   // User side
   input  wire logic tx_req_i,
   input  wire logic rsp_expect_i,
   input  wire logic wait_rsp_i,
   input  wire logic tx_end_i,
   output logic      tx_start_o,
   output logic      rsp_late_o,
   output logic      timeout_o,
   output logic      rx_start_o,
   // Link
   uit_link_if.dev_mp link
);
   // ----------------------------------------------------------------------
   // Gap counter and state
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {UD_IDLE, UD_TX, UD_WAIT} uit_dst_t;

   uit_dst_t          st_ff, nxt_st;
   logic [UIT_CW-1:0] gap_ff, nxt_gap;
   logic              rsp_ff, nxt_rsp;
   logic              start_ff, nxt_start;
   logic              late_ff, nxt_late;
   logic              to_ff, nxt_to;
   logic              rx_ff, nxt_rx;
   logic              eop_ff, nxt_eop;
   // Pending response has passed its window at the current gap
   logic              late_now;

   // ----------------------------------------------------------------------
   // Limit decoding
   // ----------------------------------------------------------------------
   function automatic logic [UIT_CW-1:0] min_gap(input uit_speed_t s);
      min_gap = (s == UIT_HS) ? UIT_HS_MIN_TURN : UIT_LF_MIN_GAP;
   endfunction : min_gap

   function automatic logic [UIT_CW-1:0] rsp_max(input uit_speed_t s,
                                                 input logic c);
      if (s == UIT_HS)
         rsp_max = c ? UIT_HS_CAP_MAX : UIT_HS_RSP_MAX;
      else
         rsp_max = c ? UIT_CAP_RSP_MAX : UIT_DET_RSP_MAX;
   endfunction : rsp_max

   function automatic logic [UIT_CW-1:0] to_fire(input uit_speed_t s);
      to_fire = (s == UIT_HS) ? UIT_HS_TO_FIRE : UIT_LF_TO_FIRE;
   endfunction : to_fire

   function automatic logic is_late(input uit_speed_t        s,
                                    input logic              c,
                                    input logic [UIT_CW-1:0] g);
      // Captive low/full-speed limit is strict, the others inclusive
      if (c && s != UIT_HS)
         is_late = (g >= rsp_max(s, c));
      else
         is_late = (g > rsp_max(s, c));
   endfunction : is_late

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      late_now  = rsp_ff && is_late(link.speed, captive_i, gap_ff);
      nxt_st    = st_ff;
      nxt_gap   = gap_ff;
      nxt_rsp   = rsp_ff;
      nxt_start = 1'b0;
      nxt_late  = 1'b0;
      nxt_to    = 1'b0;
      nxt_rx    = 1'b0;
      nxt_eop   = 1'b0;
      // Counts half bits at the current rate and saturates at UIT_CNT_MAX
      if (bit_tick_i && gap_ff != UIT_CNT_MAX)
         nxt_gap = gap_ff + 1'b1;
      unique case (st_ff)
         UD_IDLE:
         begin
            if (link.host_sop)
            begin
               nxt_rx = 1'b1;
            end
            else if (link.host_eop)
            begin
               nxt_gap = '0;
               nxt_rsp = rsp_expect_i;
            end
            else if (tx_req_i && gap_ff >= min_gap(link.speed))
            begin
               nxt_start = 1'b1;
               nxt_late  = late_now;
               nxt_rsp   = 1'b0;
               nxt_st    = UD_TX;
            end
            else if (late_now)
            begin
               nxt_late = 1'b1;
               nxt_rsp  = 1'b0;
            end
         end
         // Own packet on the line until its end
         UD_TX:
         begin
            if (tx_end_i)
            begin
               nxt_eop = 1'b1;
               nxt_gap = '0;
               nxt_st  = wait_rsp_i ? UD_WAIT : UD_IDLE;
            end
         end
         // Response or timeout, whichever comes first
         UD_WAIT:
         begin
            if (link.host_sop && gap_ff < to_fire(link.speed))
            begin
               nxt_rx = 1'b1;
               nxt_st = UD_IDLE;
            end
            else if (gap_ff >= to_fire(link.speed))
            begin
               nxt_to = 1'b1;
               nxt_st = UD_IDLE;
            end
         end
         default:
         begin
            nxt_st = UD_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_ff    <= UD_IDLE;
         gap_ff   <= UIT_CNT_MAX;
         rsp_ff   <= 1'b0;
         start_ff <= 1'b0;
         late_ff  <= 1'b0;
         to_ff    <= 1'b0;
         rx_ff    <= 1'b0;
         eop_ff   <= 1'b0;
      end
      else if (clk_en_i)
      begin
         st_ff    <= nxt_st;
         gap_ff   <= nxt_gap;
         rsp_ff   <= nxt_rsp;
         start_ff <= nxt_start;
         late_ff  <= nxt_late;
         to_ff    <= nxt_to;
         rx_ff    <= nxt_rx;
         eop_ff   <= nxt_eop;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign tx_start_o   = start_ff;
   assign rsp_late_o   = late_ff;
   assign timeout_o    = to_ff;
   assign rx_start_o   = rx_ff;
   assign link.dev_sop = start_ff;
   assign link.dev_eop = eop_ff;
endmodule : uit_dev_end

// File: src/uit_pkg.sv
// Package for the inter-packet timing pair: speed codes and bit-time limits.
// Assumes both ends run on one 100 MHz clock with a one-cycle bit strobe.
package uit_pkg;
   // ----------------------------------------------------------------------
   // Speeds
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {UIT_LS, UIT_FS, UIT_HS} uit_speed_t;

   // ----------------------------------------------------------------------
   // Bit-time limits, in half bit times so 6.5 and 7.5 stay exact
   // ----------------------------------------------------------------------
   localparam int                UIT_CW           = 11;
   localparam logic [UIT_CW-1:0] UIT_LF_MIN_GAP   = 11'h004; // 2 bits
   localparam logic [UIT_CW-1:0] UIT_DET_RSP_MAX  = 11'h00D; // 6.5 bits
   localparam logic [UIT_CW-1:0] UIT_CAP_RSP_MAX  = 11'h00F; // 7.5 bits
   localparam logic [UIT_CW-1:0] UIT_HOST_RSP_MAX = 11'h00F; // 7.5 bits
   localparam logic [UIT_CW-1:0] UIT_LF_TO_MIN    = 11'h020; // 16 bits
   localparam logic [UIT_CW-1:0] UIT_LF_TO_FIRE   = 11'h022; // 17 bits
   localparam logic [UIT_CW-1:0] UIT_LF_HOST_WAIT = 11'h024; // 18 bits
   localparam logic [UIT_CW-1:0] UIT_HS_MIN_TURN  = 11'h010; // 8 bits
   localparam logic [UIT_CW-1:0] UIT_HS_B2B_GAP   = 11'h0B0; // 88 bits
   localparam logic [UIT_CW-1:0] UIT_HS_RSP_MAX   = 11'h180; // 192 bits
   localparam logic [UIT_CW-1:0] UIT_HS_TO_MIN    = 11'h5C0; // 736 bits
   localparam logic [UIT_CW-1:0] UIT_HS_TO_FIRE   = 11'h600; // 768 bits
   localparam logic [UIT_CW-1:0] UIT_CNT_MAX      = 11'h7FF;
   // Captive cable round trip 52 ns, counted in half HS bits (1.04 ns)
   localparam int                UIT_CAP_CABLE_NS = 52;
   localparam logic [UIT_CW-1:0] UIT_HS_CAP_ADD   =
      UIT_CW'((UIT_CAP_CABLE_NS * 1000) / 1042);
   localparam logic [UIT_CW-1:0] UIT_HS_CAP_MAX   =
      UIT_CW'(UIT_HS_RSP_MAX + UIT_HS_CAP_ADD);
endpackage : uit_pkg

// File: src/uit_link_if.sv
// Link between device end and host end: line events and transmit starts.
// Assumes one shared clock; the testbench connects the two modports.
`timescale 1ns/10ps
interface uit_link_if;
   import uit_pkg::*;
   logic       dev_sop;   // Device begins a packet (J-to-K / leaves idle)
   logic       dev_eop;   // Device packet end (SE0-to-J / back to idle)
   logic       host_sop;
   logic       host_eop;
   uit_speed_t speed;     // Rate of the current packets, driven by host

   modport dev_mp  (output dev_sop, output dev_eop,
                    input host_sop, input host_eop, input speed);
   modport host_mp (output host_sop, output host_eop, output speed,
                    input dev_sop, input dev_eop);
endinterface : uit_link_if

// File: src/uit_host_end.sv
// Host end: gap timing, response window and response timeout.
// Assumes bit_tick_i is a one-cycle strobe at half the current bit period.
`timescale 1ns/10ps
module uit_host_end
   import uit_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       clk_en_i,
   // Timing
   input  wire logic       bit_tick_i,
   input  wire uit_speed_t speed_i,
   // User side
   input  wire logic       tx_req_i,
   input  wire logic       new_trans_i,
   input  wire logic       wait_rsp_i,
   input  wire logic       tx_end_i,
   output logic            tx_start_o,
   output logic            gap_late_o,
   output logic            timeout_o,
   output logic            rx_start_o,
   // Link
   uit_link_if.host_mp     link
);
   // ----------------------------------------------------------------------
   // Gap counter and state
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {UH_IDLE, UH_TX, UH_WAIT} uit_hst_t;

   uit_hst_t          st_ff, nxt_st;
   logic [UIT_CW-1:0] gap_ff, nxt_gap;
   logic              last_tx_ff, nxt_last_tx;
   logic              in_tr_ff, nxt_in_tr;
   logic              start_ff, nxt_start;
   logic              late_ff, nxt_late;
   logic              to_ff, nxt_to;
   logic              rx_ff, nxt_rx;
   logic              eop_ff, nxt_eop;
   logic              spd_ok;
   logic [UIT_CW-1:0] need;
   logic [UIT_CW-1:0] lim;

   always_comb
   begin
      spd_ok = (speed_i == UIT_HS);
      // At HS, own packet last on the line means back-to-back spacing
      if (new_trans_i && !spd_ok)
         need = UIT_LF_HOST_WAIT;
      else if (spd_ok)
         need = last_tx_ff ? UIT_HS_B2B_GAP : UIT_HS_MIN_TURN;
      else
         need = UIT_LF_MIN_GAP;
      lim = spd_ok ? UIT_HS_RSP_MAX : UIT_HOST_RSP_MAX;
   end

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_gap     = gap_ff;
      nxt_last_tx = last_tx_ff;
      nxt_in_tr   = in_tr_ff;
      nxt_start   = 1'b0;
      nxt_late    = 1'b0;
      nxt_to      = 1'b0;
      nxt_rx      = 1'b0;
      nxt_eop     = 1'b0;
      if (bit_tick_i && gap_ff != UIT_CNT_MAX)
         nxt_gap = gap_ff + 1'b1;
      unique case (st_ff)
         UH_IDLE:
         begin
            if (link.dev_sop)
            begin
               nxt_rx = 1'b1;
            end
            else if (link.dev_eop)
            begin
               nxt_gap     = '0;
               nxt_last_tx = 1'b0;
               nxt_in_tr   = 1'b1;
            end
            else if (tx_req_i && gap_ff >= need)
            begin
               nxt_start = 1'b1;
               nxt_late  = in_tr_ff && !new_trans_i && gap_ff > lim;
               nxt_st    = UH_TX;
            end
         end
         UH_TX:
         begin
            if (tx_end_i)
            begin
               nxt_eop     = 1'b1;
               nxt_gap     = '0;
               nxt_last_tx = 1'b1;
               nxt_in_tr   = 1'b1;
               nxt_st      = wait_rsp_i ? UH_WAIT : UH_IDLE;
            end
         end
         UH_WAIT:
         begin
            if (link.dev_sop && gap_ff < (spd_ok ? UIT_HS_TO_FIRE
                                                  : UIT_LF_TO_FIRE))
            begin
               nxt_rx = 1'b1;
               nxt_st = UH_IDLE;
            end
            else if (gap_ff >= (spd_ok ? UIT_HS_TO_FIRE : UIT_LF_TO_FIRE))
            begin
               nxt_to    = 1'b1;
               nxt_in_tr = 1'b0;
               nxt_st    = UH_IDLE;
            end
         end
         default:
         begin
            nxt_st = UH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_ff      <= UH_IDLE;
         gap_ff     <= UIT_CNT_MAX;
         last_tx_ff <= 1'b0;
         in_tr_ff   <= 1'b0;
         start_ff   <= 1'b0;
         late_ff    <= 1'b0;
         to_ff      <= 1'b0;
         rx_ff      <= 1'b0;
         eop_ff     <= 1'b0;
      end
      else if (clk_en_i)
      begin
         st_ff      <= nxt_st;
         gap_ff     <= nxt_gap;
         last_tx_ff <= nxt_last_tx;
         in_tr_ff   <= nxt_in_tr;
         start_ff   <= nxt_start;
         late_ff    <= nxt_late;
         to_ff      <= nxt_to;
         rx_ff      <= nxt_rx;
         eop_ff     <= nxt_eop;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign tx_start_o    = start_ff;
   assign gap_late_o    = late_ff;
   assign timeout_o     = to_ff;
   assign rx_start_o    = rx_ff;
   assign link.host_sop = start_ff;
   assign link.host_eop = eop_ff;
   assign link.speed    = speed_i;
endmodule : uit_host_end

// File: verif/uit_assertions.sv
// Checker on the link joining the device end and the host end.
// Assumes one bit tick per clock, so one cycle is one half bit.
`timescale 1ns/10ps
module uit_assertions
   import uit_pkg::*;
(
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   // Link
   input wire logic       dev_sop,
   input wire logic       dev_eop,
   input wire logic       host_sop,
   input wire logic       host_eop,
   input wire uit_speed_t speed
);
   // ----
   // Gap since the last end of packet, and who sent it
   // ----
   logic [UIT_CW-1:0] gap_ff, nxt_gap, need;
   logic              hl_ff, nxt_hl, hs;

   always_comb
   begin
      hs      = (speed == UIT_HS);
      need    = hs ? UIT_HS_MIN_TURN : UIT_LF_MIN_GAP;
      nxt_gap = (dev_eop | host_eop) ? '0 :
                gap_ff + UIT_CW'(gap_ff != UIT_CNT_MAX);
      nxt_hl  = host_eop | (hl_ff & ~dev_eop);
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         gap_ff <= UIT_CNT_MAX;
         hl_ff  <= 1'b0;
      end
      else
      begin
         gap_ff <= nxt_gap;
         hl_ff  <= nxt_hl;
      end
   end

   // ----
   // Properties
   // ----
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_dev_close;
      ##[2:64] dev_eop;
   endsequence
   sequence s_host_close;
      ##[2:64] host_eop;
   endsequence

   a_dev_min_gap: assert property (dev_sop |-> gap_ff >= need)
      else $error("device packet inside the minimum gap");
   a_host_turn_gap: assert property (
      host_sop && !(hl_ff && hs) |-> gap_ff >= need)
      else $error("host packet inside the minimum gap");
   a_host_b2b_gap: assert property (
      host_sop && hl_ff && hs |-> gap_ff >= UIT_HS_B2B_GAP)
      else $error("host back-to-back gap too short");
   a_dev_frame_end: assert property (dev_sop |-> s_dev_close)
      else $error("device packet not closed");
   a_host_frame_end: assert property (host_sop |-> s_host_close)
      else $error("host packet not closed");
   a_dev_frame_alone: assert property (
      dev_sop |=> (!dev_sop && !host_sop) until dev_eop)
      else $error("second start inside a device packet");
   a_host_frame_alone: assert property (
      host_sop |=> (!host_sop && !dev_sop) until host_eop)
      else $error("second start inside a host packet");
   a_rate_hold: assert property (
      dev_sop || host_sop |=> $stable(speed) until (dev_eop || host_eop))
      else $error("rate changed inside a packet");
endmodule : uit_assertions

// File: verif/testbench.sv
// Bench: device end and host end joined by the link interface.
// Assumes one bit tick per clock, so one cycle is one half bit.
`timescale 1ns/10ps
module testbench
   import uit_pkg::*;
;
   logic        clk_i, rst_b_i, cap, rexp, ntr;
   logic [1:0]  req, wt, te, ts, late, tmo, rxs;
   uit_speed_t  spd;
   logic [31:0] seed;
   integer      err_count, compares, cyc, t_eop, t_sop, t_to, t0;
   integer      n_late [2], n_to [2], n_rx [2];

   uit_link_if lk ();
   uit_dev_end u_uit_dev_end (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .clk_en_i(1'b1), .bit_tick_i(1'b1), .captive_i(cap),
      .tx_req_i(req[0]), .rsp_expect_i(rexp), .wait_rsp_i(wt[0]),
      .tx_end_i(te[0]), .tx_start_o(ts[0]), .rsp_late_o(late[0]),
      .timeout_o(tmo[0]), .rx_start_o(rxs[0]), .link(lk));
   uit_host_end u_uit_host_end (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .clk_en_i(1'b1), .bit_tick_i(1'b1), .speed_i(spd),
      .tx_req_i(req[1]), .new_trans_i(ntr), .wait_rsp_i(wt[1]),
      .tx_end_i(te[1]), .tx_start_o(ts[1]), .gap_late_o(late[1]),
      .timeout_o(tmo[1]), .rx_start_o(rxs[1]), .link(lk));
   uit_assertions u_uit_assertions (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .dev_sop(lk.dev_sop), .dev_eop(lk.dev_eop), .host_sop(lk.host_sop),
      .host_eop(lk.host_eop), .speed(lk.speed));

   // ----
   // Clock and event monitor
   // ----
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(negedge clk_i)
   begin
      cyc = cyc + 1;
      if (lk.dev_eop || lk.host_eop)
         t_eop = cyc;
      if (lk.dev_sop || lk.host_sop)
         t_sop = cyc;
      for (int i = 0; i < 2; i++)
      begin
         n_late[i] = n_late[i] + late[i];
         n_to[i]   = n_to[i] + tmo[i];
         n_rx[i]   = n_rx[i] + rxs[i];
         if (tmo[i] === 1'b1)
            t_to = cyc;
      end
      if (cyc > 40000)
      begin
         err_count = err_count + 1;
         print_verdict();
      end
   end

   // ----
   // Tasks
   // ----
   function automatic int rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return int'(seed[15:0]);
   endfunction : rnd

   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tk

   task automatic clr();
      n_late = '{0, 0};
      n_to   = '{0, 0};
      n_rx   = '{0, 0};
   endtask : clr

   task automatic chk(input integer got, input integer exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("Error at %0t: got %0d, expected %0d", $time, got, exp);
      end
   endtask : chk

   // One packet from end h; holds the request until it is granted
   task automatic send(input int h, input logic w);
      req[h] = 1'b1;
      while (ts[h] !== 1'b1)
         tk(1);
      req[h] = 1'b0;
      tk(3 + rnd() % 5);
      te[h] = 1'b1;
      wt[h] = w;
      tk(1);
      te[h] = 1'b0;
      tk(2);
   endtask : send

   // End h asks, the other end answers after d half bits or never
   task automatic xact(input int h, input int d);
      int lim, lo, hi;
      clr();
      rexp = (h == 1);
      ntr  = (h == 1);
      if (spd == UIT_HS)
      begin
         lim = (h == 1 && cap) ? UIT_HS_CAP_MAX : UIT_HS_RSP_MAX;
         lo  = 2 * 736;
         hi  = 2 * 816;
      end
      else
      begin
         lim = h ? (cap ? UIT_CAP_RSP_MAX - 1 : UIT_DET_RSP_MAX)
                 : UIT_HOST_RSP_MAX;
         lo  = 2 * 16;
         hi  = 2 * 18 - 1;
      end
      send(h, 1'b1);
      t0 = t_eop;
      if (d < 0)
         tk(hi + 8);
      else
      begin
         while (cyc < t0 + d)
            tk(1);
         ntr = 1'b0;
         send(1 - h, 1'b0);
      end
      chk(n_late[1 - h], (d > lim) || (d < 0 && h == 1));
      chk(n_rx[h], d >= 0);
      chk(n_to[h], d < 0);
      if (d < 0)
         chk(t_to - t0 >= lo && t_to - t0 <= hi, 1);
   endtask : xact

   task automatic print_verdict();
      $display("Comparisons %0d, errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // ----
   // Main sequence
   // ----
   initial
   begin
      rst_b_i = 1'b0;
      {req, wt, te} = '0;
      {cap, rexp, ntr} = '0;
      spd  = UIT_FS;
      seed = 32'h5EF9BEAE;
      {err_count, compares, cyc, t_eop, t_sop, t_to} = '0;
      clr();
      repeat (16) @(posedge clk_i);
      #1;
      rst_b_i = 1'b1;
      tk(2);
      for (int h = 0; h < 2; h++)
         for (int c = 0; c < 2; c++)
         begin
            cap = c[0];
            spd = (rnd() % 2) ? UIT_FS : UIT_LS;
            xact(h, 3 + rnd() % 6);
            xact(h, 20);
            xact(h, -1);
            spd = UIT_HS;
            xact(h, 20 + rnd() % 280);
            xact(h, 400);
            xact(h, -1);
         end
      spd = UIT_LS;
      clr();
      rexp = 1'b0;
      ntr  = 1'b1;
      send(1, 1'b1);
      t0 = t_eop;
      send(1, 1'b0);
      chk(t_sop - t0 >= 2 * 18, 1);
      chk(n_to[1], 1);
      spd = UIT_HS;
      ntr = 1'b0;
      clr();
      send(1, 1'b0);
      t0 = t_eop;
      send(1, 1'b0);
      chk(t_sop - t0 >= 2 * 88, 1);
      chk(n_late[1], 0);
      tk(2100);
      ntr = 1'b1;
      send(1, 1'b0);
      chk(n_late[0] + n_late[1], 0);
      chk(n_to[0] + n_to[1], 0);
      print_verdict();
   end
endmodule : testbench
